//--- design/gate_if.sv
`timescale 1ns/10ps
interface gate_if;
  pdm_pkg::mode_t mode;
  logic [pdm_pkg::CS_W-1:0] clkSrc;
  logic timerARun;
  logic timerCRun;
  logic timerGFRun;
  logic serialOneRun;
  logic serialTwoRun;
  logic serialReset;
  logic wdtRun;
  logic lcdRun;
  logic pwmAdcRun;
  modport ctl (output mode, output clkSrc, input timerARun, input timerCRun, input timerGFRun,
    input serialOneRun, input serialTwoRun, input serialReset, input wdtRun, input lcdRun, input pwmAdcRun);
  modport gate (input mode, input clkSrc, output timerARun, output timerCRun, output timerGFRun,
    output serialOneRun, output serialTwoRun, output serialReset, output wdtRun, output lcdRun, output pwmAdcRun);
endinterface

//--- design/pdm_pkg.sv
package pdm_pkg;
  typedef enum logic [2:0] {ACT_HS, ACT_MS, SUBACT, SLEEP_HS, SLEEP_MS, SUBSLEEP, WATCH, STANDBY} mode_t;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_CLKSRC = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_AEC = 8'h18;

  // control register 1 fields
  localparam int C1_STBY = 7;
  localparam int C1_LSW = 3;
  localparam int C1_RSV = 2;
  localparam int C1_DIV = 0;
  localparam logic [1:0] DIV_RESET = 2'h3;
  // control register 2 fields, bits 7..5 read as one
  localparam int C2_DTB = 3;
  localparam int C2_MSS = 2;
  localparam logic [7:0] C2_RSV = 8'he0;
  // clock source register: six 3-bit fields then the time-base select
  localparam int CS_C = 0;
  localparam int CS_GF = 3;
  localparam int CS_S1 = 6;
  localparam int CS_S2 = 9;
  localparam int CS_WDT = 12;
  localparam int CS_LCD = 15;
  localparam int CS_TMA = 18;
  localparam int CS_W = 19;

  // peripheral clock source codes
  localparam logic [2:0] SRC_SYS = 3'h0;
  localparam logic [2:0] SRC_EXT = 3'h1;
  localparam logic [2:0] SRC_SUB = 3'h2;
  localparam logic [2:0] SRC_SUB2 = 3'h3;
  localparam logic [2:0] SRC_SUB4 = 3'h4;
  localparam logic [2:0] SRC_SUB32 = 3'h5;

  // status layout: ext lines 4..0, wake pins 12..5, counter overflow 13
  localparam int ST_W = 14;
  localparam int ST_AEC = 13;
  localparam logic [4:0] EXT_KEEP_WS = 5'h01;
  localparam logic [7:0] DIV_MIN = 8'h10;

  function automatic logic watch_or_standby(input mode_t m);
    return (m == WATCH) || (m == STANDBY);
  endfunction

  function automatic logic on_subclock(input mode_t m);
    return (m == WATCH) || (m == SUBACT) || (m == SUBSLEEP);
  endfunction
endpackage

//--- design/peripheral_gate.sv
`timescale 1ns/10ps
module peripheral_gate (
  input wire logic ref_clk,
  input wire logic resetn,
  gate_if.gate g
);
  logic [2:0] srcC, srcGF, srcS1, srcS2, srcWdt, srcLcd;
  logic subMode, stby, ws;
  assign srcC = g.clkSrc[pdm_pkg::CS_C +: 3];
  assign srcGF = g.clkSrc[pdm_pkg::CS_GF +: 3];
  assign srcS1 = g.clkSrc[pdm_pkg::CS_S1 +: 3];
  assign srcS2 = g.clkSrc[pdm_pkg::CS_S2 +: 3];
  assign srcWdt = g.clkSrc[pdm_pkg::CS_WDT +: 3];
  assign srcLcd = g.clkSrc[pdm_pkg::CS_LCD +: 3];
  assign subMode = pdm_pkg::on_subclock(g.mode);
  assign stby = g.mode == pdm_pkg::STANDBY;
  assign ws = pdm_pkg::watch_or_standby(g.mode);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      g.timerARun <= 1'b1;
      g.timerCRun <= 1'b1;
      g.timerGFRun <= 1'b1;
      g.serialOneRun <= 1'b1;
      g.serialTwoRun <= 1'b1;
      g.serialReset <= 1'b0;
      g.wdtRun <= 1'b1;
      g.lcdRun <= 1'b1;
      g.pwmAdcRun <= 1'b1;
    end else begin
      g.timerARun <= !stby && (!subMode || g.clkSrc[pdm_pkg::CS_TMA]);
      g.timerCRun <= !ws && (!subMode || srcC == pdm_pkg::SRC_EXT || srcC == pdm_pkg::SRC_SUB4);
      g.timerGFRun <= !stby && (!subMode || srcGF == pdm_pkg::SRC_EXT || srcGF == pdm_pkg::SRC_SUB4);
      // subsleep treated like subactive for the serial units
      g.serialOneRun <= !ws && (!subMode || srcS1 == pdm_pkg::SRC_SUB2);
      g.serialTwoRun <= !ws && (!subMode || srcS2 == pdm_pkg::SRC_SUB2);
      g.serialReset <= ws;
      g.wdtRun <= (g.mode == pdm_pkg::SUBACT) ? srcWdt == pdm_pkg::SRC_SUB32 : !(ws || subMode);
      g.lcdRun <= !stby && (!subMode || srcLcd == pdm_pkg::SRC_SUB || srcLcd == pdm_pkg::SRC_SUB2
        || srcLcd == pdm_pkg::SRC_SUB4);
      g.pwmAdcRun <= !(ws || subMode);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  timer_a_gate_a: assert property ($past(subMode) && !$past(g.clkSrc[pdm_pkg::CS_TMA]) |-> !g.timerARun)
    else $error("timer A runs without time-base select in subclock mode");
  wdt_gate_a: assert property ($past(g.mode) == pdm_pkg::SUBACT
    |-> g.wdtRun == ($past(srcWdt) == pdm_pkg::SRC_SUB32))
    else $error("watchdog gating wrong in subactive mode");
  serial_reset_a: assert property ($past(ws) |-> g.serialReset && !g.serialOneRun && !g.pwmAdcRun)
    else $error("serial units not held in reset in watch or standby");
  lcd_stby_a: assert property ($past(stby) |-> !g.lcdRun && !g.timerGFRun)
    else $error("lcd or timer G/F running in standby");
endmodule

//--- design/power_down_mode_control.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module power_down_mode_control (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic sleepReq,
  input wire logic intAccept,
  input wire logic [4:0] extIntPin,
  input wire logic [7:0] wakeupPin,
  input wire logic aecPin,
  output logic irqOut,
  output logic [2:0] modeState,
  output logic cpuRun,
  output logic cpuOnSubclock,
  output logic sysOscEn,
  output logic subOscEn,
  output logic portHiZ,
  output logic mediumTick,
  output logic timerARun,
  output logic timerCRun,
  output logic timerGFRun,
  output logic serialOneRun,
  output logic serialTwoRun,
  output logic serialReset,
  output logic wdtRun,
  output logic lcdRun,
  output logic pwmAdcRun
);
  pdm_pkg::mode_t mode, next_mode, activeTarget;
  logic standbyBit, lowSpeedWake, directTransfer, mediumSpeedSel;
  logic [1:0] mediumDiv;
  logic [pdm_pkg::CS_W-1:0] clkSrc;
  logic [pdm_pkg::ST_W-1:0] status, mask, setVec, clrVec;
  logic [13:0] pinMeta, pinSync, pinPrev, pinRise;
  logic [7:0] aecCount, divCnt, divLast;
  logic [4:0] extOk;
  logic aecOvf, ws, statWr, wakeOk;

  gate_if gif();

  peripheral_gate u_gate (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .g(gif.gate)
  );

  assign gif.mode = mode;
  assign gif.clkSrc = clkSrc;
  assign timerARun = gif.timerARun;
  assign timerCRun = gif.timerCRun;
  assign timerGFRun = gif.timerGFRun;
  assign serialOneRun = gif.serialOneRun;
  assign serialTwoRun = gif.serialTwoRun;
  assign serialReset = gif.serialReset;
  assign wdtRun = gif.wdtRun;
  assign lcdRun = gif.lcdRun;
  assign pwmAdcRun = gif.pwmAdcRun;
  assign modeState = mode;

  // pins are asynchronous: two stages before the edge detector
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinMeta <= 14'h0000;
      pinSync <= 14'h0000;
      pinPrev <= 14'h0000;
    end else begin
      pinMeta <= {aecPin, wakeupPin, extIntPin};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end
  assign pinRise = pinSync & ~pinPrev;

  assign ws = pdm_pkg::watch_or_standby(mode);
  assign statWr = regWr && regAddr == pdm_pkg::OFS_STAT;

  // control registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      standbyBit <= 1'b0;
      lowSpeedWake <= 1'b0;
      mediumDiv <= pdm_pkg::DIV_RESET;
      directTransfer <= 1'b0;
      mediumSpeedSel <= 1'b0;
      clkSrc <= '0;
      mask <= '0;
    end else if (regWr) begin
      case (regAddr)
        pdm_pkg::OFS_CTRL1: begin
          standbyBit <= regWdata[pdm_pkg::C1_STBY];
          lowSpeedWake <= regWdata[pdm_pkg::C1_LSW];
          mediumDiv <= regWdata[pdm_pkg::C1_DIV +: 2];
        end
        pdm_pkg::OFS_CTRL2: begin
          directTransfer <= regWdata[pdm_pkg::C2_DTB];
          mediumSpeedSel <= regWdata[pdm_pkg::C2_MSS];
        end
        pdm_pkg::OFS_CLKSRC: begin
          clkSrc <= regWdata[pdm_pkg::CS_W-1:0];
        end
        pdm_pkg::OFS_MASK: begin
          mask <= regWdata[pdm_pkg::ST_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // event counter keeps counting in every mode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      aecCount <= 8'h00;
    end else if (pinRise[13]) begin
      aecCount <= aecCount + 8'h01;
    end
  end
  assign aecOvf = pinRise[13] && aecCount == 8'hff;

  // sticky status; a set in the clearing cycle wins
  assign extOk = ws ? pdm_pkg::EXT_KEEP_WS : 5'h1f;
  assign setVec = {aecOvf && !ws, pinRise[12:5], pinRise[4:0] & extOk};
  assign clrVec = statWr ? regWdata[pdm_pkg::ST_W-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status <= '0;
      irqOut <= 1'b0;
    end else begin
      status <= (status & ~clrVec) | setVec;
      irqOut <= |(status & mask);
    end
  end

  // wake only on an accepted, pending interrupt, never on the raw request
  assign wakeOk = intAccept && irqOut;
  assign activeTarget = mediumSpeedSel ? pdm_pkg::ACT_MS : pdm_pkg::ACT_HS;

  always_comb begin
    next_mode = mode;
    case (mode)
      pdm_pkg::ACT_HS, pdm_pkg::ACT_MS: begin
        if (sleepReq) begin
          if (!directTransfer) begin
            if (!standbyBit) begin
              next_mode = mediumSpeedSel ? pdm_pkg::SLEEP_MS : pdm_pkg::SLEEP_HS;
            end else begin
              next_mode = directTransfer ? mode : (pdm_pkg::STANDBY);
              if (clkSrc[pdm_pkg::CS_TMA]) begin
                next_mode = pdm_pkg::WATCH;
              end
            end
          end else if (!standbyBit) begin
            next_mode = activeTarget;
          end else if (clkSrc[pdm_pkg::CS_TMA]) begin
            next_mode = lowSpeedWake ? pdm_pkg::SUBACT : activeTarget;
          end else begin
            next_mode = pdm_pkg::STANDBY;
          end
        end
      end
      pdm_pkg::SUBACT: begin
        if (sleepReq) begin
          if (directTransfer && standbyBit && clkSrc[pdm_pkg::CS_TMA] && !lowSpeedWake) begin
            next_mode = activeTarget;
          end else begin
            next_mode = standbyBit ? pdm_pkg::WATCH : pdm_pkg::SUBSLEEP;
          end
        end
      end
      pdm_pkg::SLEEP_HS: begin
        if (wakeOk) next_mode = pdm_pkg::ACT_HS;
      end
      pdm_pkg::SLEEP_MS: begin
        if (wakeOk) next_mode = pdm_pkg::ACT_MS;
      end
      pdm_pkg::SUBSLEEP: begin
        if (wakeOk) next_mode = pdm_pkg::SUBACT;
      end
      pdm_pkg::WATCH: begin
        if (wakeOk) next_mode = lowSpeedWake ? pdm_pkg::SUBACT : activeTarget;
      end
      pdm_pkg::STANDBY: begin
        if (wakeOk) next_mode = activeTarget;
      end
      default: begin
        next_mode = pdm_pkg::ACT_HS;
      end
    endcase
  end

  // mode and the cpu, oscillator and port outputs move on the same edge; the peripheral run outputs follow one edge later
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode <= pdm_pkg::ACT_HS;
      cpuRun <= 1'b1;
      cpuOnSubclock <= 1'b0;
      sysOscEn <= 1'b1;
      subOscEn <= 1'b1;
      portHiZ <= 1'b0;
    end else begin
      mode <= next_mode;
      cpuRun <= next_mode == pdm_pkg::ACT_HS || next_mode == pdm_pkg::ACT_MS || next_mode == pdm_pkg::SUBACT;
      cpuOnSubclock <= pdm_pkg::on_subclock(next_mode);
      sysOscEn <= !(pdm_pkg::on_subclock(next_mode) || next_mode == pdm_pkg::STANDBY);
      subOscEn <= 1'b1;
      portHiZ <= next_mode == pdm_pkg::STANDBY;
    end
  end

  // medium-speed clock enable from the oscillator prescaler
  assign divLast = (pdm_pkg::DIV_MIN << mediumDiv) - 8'h01;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      divCnt <= 8'h00;
      mediumTick <= 1'b0;
    end else if (mode == pdm_pkg::ACT_MS || mode == pdm_pkg::SLEEP_MS) begin
      mediumTick <= divCnt == divLast;
      divCnt <= (divCnt == divLast) ? 8'h00 : divCnt + 8'h01;
    end else begin
      divCnt <= 8'h00;
      mediumTick <= 1'b0;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        pdm_pkg::OFS_CTRL1: regRdata <= 32'({standbyBit, 3'h0, lowSpeedWake, 1'b1, mediumDiv});
        pdm_pkg::OFS_CTRL2: regRdata <= 32'(pdm_pkg::C2_RSV | 8'({directTransfer, mediumSpeedSel, 2'h0}));
        pdm_pkg::OFS_CLKSRC: regRdata <= 32'(clkSrc);
        pdm_pkg::OFS_STAT: regRdata <= 32'(status);
        pdm_pkg::OFS_MASK: regRdata <= 32'(mask);
        pdm_pkg::OFS_MODE: regRdata <= 32'(mode);
        pdm_pkg::OFS_AEC: regRdata <= 32'(aecCount);
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  wake_needs_accept_a: assert property (
    $past(mode) inside {pdm_pkg::SLEEP_HS, pdm_pkg::SLEEP_MS, pdm_pkg::SUBSLEEP, pdm_pkg::WATCH,
    pdm_pkg::STANDBY} && mode != $past(mode) |-> $past(intAccept) && $past(irqOut))
    else $error("left a power-down mode without an accepted interrupt");
  port_hiz_a: assert property ((mode == pdm_pkg::STANDBY) == portHiZ)
    else $error("port high impedance does not match standby");
  irq_hold_a: assert property ($past(ws) && !$past(statWr) |-> status[4:1] == $past(status[4:1]))
    else $error("retained external flag changed in watch or standby");
  aec_quiet_a: assert property ($rose(status[pdm_pkg::ST_AEC]) |-> !$past(ws))
    else $error("event counter interrupt raised in watch or standby");
  osc_stop_a: assert property (sysOscEn == (mode inside {pdm_pkg::ACT_HS, pdm_pkg::ACT_MS,
    pdm_pkg::SLEEP_HS, pdm_pkg::SLEEP_MS}) && subOscEn)
    else $error("oscillator enables disagree with mode");
  sleep_entry_a: assert property (sleepReq && mode == pdm_pkg::ACT_HS && !directTransfer && !standbyBit
    && !mediumSpeedSel |=> mode == pdm_pkg::SLEEP_HS)
    else $error("sleep did not enter high-speed sleep");
  watch_exit_a: assert property ($past(mode) == pdm_pkg::WATCH && mode != pdm_pkg::WATCH
    |-> (mode == pdm_pkg::SUBACT) == $past(lowSpeedWake))
    else $error("watch exit ignored low-speed select");
  direct_a: assert property (sleepReq && mode == pdm_pkg::ACT_HS && directTransfer && !standbyBit
    && mediumSpeedSel |=> mode == pdm_pkg::ACT_MS)
    else $error("direct transfer to medium speed failed");
  tick_gap_a: assert property (mediumTick |=> !mediumTick [*8])
    else $error("medium tick spacing too short");
  // the prescaler only runs in the medium-speed active and sleep modes
  tick_mode_a: assert property (mediumTick |-> $past(mode) inside {pdm_pkg::ACT_MS, pdm_pkg::SLEEP_MS})
    else $error("medium tick outside medium-speed modes");
  sub_sleep_a: assert property (sleepReq && mode == pdm_pkg::SUBACT && !standbyBit
    |=> mode == pdm_pkg::SUBSLEEP)
    else $error("sleep from subactive did not enter subsleep");
  sub_watch_a: assert property (sleepReq && mode == pdm_pkg::SUBACT && standbyBit && !directTransfer
    |=> mode == pdm_pkg::WATCH)
    else $error("sleep from subactive did not enter watch");
  line_zero_a: assert property (ws && pinRise[0] |=> status[0])
    else $error("external line 0 ignored in watch or standby");
  cpu_run_a: assert property (cpuRun == (mode inside {pdm_pkg::ACT_HS, pdm_pkg::ACT_MS,
    pdm_pkg::SUBACT}))
    else $error("cpu run flag disagrees with mode");

  sleep_wake_c: cover property (mode == pdm_pkg::SLEEP_HS ##[1:50] mode == pdm_pkg::ACT_HS);
  watch_sub_c: cover property (mode == pdm_pkg::WATCH ##[1:50] mode == pdm_pkg::SUBACT);
  standby_c: cover property (mode == pdm_pkg::STANDBY ##[1:50] mode == pdm_pkg::ACT_MS);
  ws_ignore_c: cover property (ws && |pinRise[4:1]);
  standby_hs_c: cover property (mode == pdm_pkg::STANDBY ##[1:50] mode == pdm_pkg::ACT_HS);
endmodule

//--- dv/cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic irqOut,
  input wire logic [3:0] acceptDelay,
  output logic intAccept
);
  logic [4:0] waitCnt;

  // handler entry takes acceptDelay plus one cycles; one accept per request
  always_ff @(posedge ref_clk) begin
    if (!resetn || !irqOut) begin
      waitCnt <= 5'h00;
      intAccept <= 1'h0;
    end else begin
      if (waitCnt <= {1'h0, acceptDelay}) begin
        waitCnt <= waitCnt + 5'h01;
      end
      intAccept <= (waitCnt == {1'h0, acceptDelay});
    end
  end
endmodule

//--- dv/tb_power_down_mode_control.sv
`timescale 1ns/10ps
module tb_power_down_mode_control;
  logic ref_clk, resetn, regWr, regRd, sleepReq, intAccept, aecPin, irqOut;
  logic [7:0] regAddr, wakeupPin;
  logic [31:0] regWdata, regRdata, rd;
  logic [4:0] extIntPin;
  logic [2:0] modeState;
  logic [3:0] acceptDelay;
  logic cpuRun, cpuOnSubclock, sysOscEn, subOscEn, portHiZ, mediumTick;
  logic timerARun, timerCRun, timerGFRun, serialOneRun, serialTwoRun, serialReset, wdtRun, lcdRun, pwmAdcRun;
  int errorCnt = 0;
  int numChecks = 0;

  power_down_mode_control power_down_mode_control_i (.ref_clk, .resetn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .sleepReq, .intAccept, .extIntPin, .wakeupPin, .aecPin, .irqOut, .modeState, .cpuRun,
    .cpuOnSubclock, .sysOscEn, .subOscEn, .portHiZ, .mediumTick, .timerARun, .timerCRun, .timerGFRun,
    .serialOneRun, .serialTwoRun, .serialReset, .wdtRun, .lcdRun, .pwmAdcRun);
  cpu_model cpu_model_i (.ref_clk, .resetn, .irqOut, .acceptDelay, .intAccept);

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic wrapUp();
    if (errorCnt == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // sampling 1 ns after the edge keeps clear of the design's own updates
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge ref_clk);
    regWr <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rdr(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
    #1 rd = regRdata;
    @(posedge ref_clk);
  endtask

  task automatic sleep_to(input pdm_pkg::mode_t m);
    sleepReq <= 1'h1;
    @(posedge ref_clk);
    sleepReq <= 1'h0;
    #1 chk("mode after sleep", 32'(m), 32'(modeState));
    tick(1);
  endtask

  task automatic pulse(input logic [4:0] e, input logic [7:0] w);
    extIntPin <= e;
    wakeupPin <= w;
    tick(3);
    extIntPin <= 5'h00;
    wakeupPin <= 8'h00;
    tick(3);
  endtask

  task automatic aec(input int n);
    repeat (n) begin
      aecPin <= 1'h1;
      tick(2);
      aecPin <= 1'h0;
      tick(2);
    end
  endtask

  // irq already pending here, but mode must wait for the accept
  task automatic wake_to(input pdm_pkg::mode_t m, input pdm_pkg::mode_t now);
    int n;
    pulse(5'h01, 8'h00);
    chk("held mode", 32'({1'h1, now}), 32'({irqOut, modeState}));
    n = 0;
    while (modeState !== m && n < 40) begin
      tick(1);
      n++;
    end
    chk("woken mode", 32'(m), 32'(modeState));
    wr(pdm_pkg::OFS_STAT, 32'h3fff);
    tick(2);
  endtask

  task automatic gap(output int n);
    int k;
    k = 0;
    while (mediumTick !== 1'h1 && k < 300) begin
      tick(1);
      k++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while (mediumTick !== 1'h1 && n < 300);
  endtask

  function automatic logic [31:0] gv();
    return 32'({timerARun, timerCRun, timerGFRun, serialOneRun, serialTwoRun, wdtRun, lcdRun});
  endfunction

  task automatic t_reset();
    rdr(pdm_pkg::OFS_CTRL1);
    chk("ctrl1 reset", 32'h07, rd);
    rdr(pdm_pkg::OFS_CTRL2);
    chk("ctrl2 reset", 32'he0, rd);
    chk("osc reset", 32'he, 32'({cpuRun, sysOscEn, subOscEn, portHiZ}));
    wr(pdm_pkg::OFS_CTRL1, 32'h0);
    rdr(pdm_pkg::OFS_CTRL1);
    chk("ctrl1 reserved", 32'h04, rd);
    wr(pdm_pkg::OFS_MODE, 32'h5);
    rdr(pdm_pkg::OFS_MODE);
    chk("mode read only", 32'h0, rd);
    rdr(8'h1c);
    chk("unmapped", 32'h0, rd);
    wr(pdm_pkg::OFS_MASK, 32'h1);
  endtask

  task automatic t_irq();
    pulse(5'h01, 8'h80);
    chk("irq raised", 32'h1, 32'(irqOut));
    chk("no mode change", 32'(pdm_pkg::ACT_HS), 32'(modeState));
    wr(pdm_pkg::OFS_MASK, 32'h0);
    tick(1);
    chk("irq masked", 32'h0, 32'(irqOut));
    rdr(pdm_pkg::OFS_STAT);
    chk("sticky status", 32'h1001, rd);
    wr(pdm_pkg::OFS_STAT, 32'h1001);
    rdr(pdm_pkg::OFS_STAT);
    chk("status cleared", 32'h0, rd);
    wr(pdm_pkg::OFS_MASK, 32'h1);
  endtask

  task automatic t_speed();
    int n;
    wr(pdm_pkg::OFS_CTRL2, 32'h0);
    sleep_to(pdm_pkg::SLEEP_HS);
    wake_to(pdm_pkg::ACT_HS, pdm_pkg::SLEEP_HS);
    wr(pdm_pkg::OFS_CTRL2, 32'h0c);
    sleep_to(pdm_pkg::ACT_MS);
    for (int d = 0; d < 4; d++) begin
      wr(pdm_pkg::OFS_CTRL1, 32'(d));
      gap(n);
      gap(n);
      chk("tick gap", 32'(16 << d), 32'(n));
    end
    wr(pdm_pkg::OFS_CTRL2, 32'h04);
    sleep_to(pdm_pkg::SLEEP_MS);
    gap(n);
    gap(n);
    chk("sleep tick gap", 32'h80, 32'(n));
    acceptDelay <= 4'hc;
    wake_to(pdm_pkg::ACT_MS, pdm_pkg::SLEEP_MS);
    wr(pdm_pkg::OFS_CTRL2, 32'h08);
    sleep_to(pdm_pkg::ACT_HS);
  endtask

  task automatic t_standby();
    wr(pdm_pkg::OFS_CLKSRC, 32'h0);
    wr(pdm_pkg::OFS_CTRL1, 32'h80);
    wr(pdm_pkg::OFS_CTRL2, 32'h0);
    sleep_to(pdm_pkg::STANDBY);
    tick(1);
    chk("standby", 32'h2c, 32'({portHiZ, sysOscEn, subOscEn, serialReset, pwmAdcRun, cpuRun}));
    pulse(5'h1e, 8'h00);
    rdr(pdm_pkg::OFS_STAT);
    chk("lines ignored", 32'h0, rd);
    wake_to(pdm_pkg::ACT_HS, pdm_pkg::STANDBY);
  endtask

  task automatic t_watch();
    wr(pdm_pkg::OFS_CLKSRC, 32'h40000);
    wr(pdm_pkg::OFS_CTRL1, 32'h88);
    sleep_to(pdm_pkg::WATCH);
    chk("watch clocks", 32'h2, 32'({cpuOnSubclock, sysOscEn}));
    aec(3);
    rdr(pdm_pkg::OFS_AEC);
    chk("event count", 32'h3, rd);
    aec(253);
    rdr(pdm_pkg::OFS_AEC);
    chk("count wrapped", 32'h0, rd);
    rdr(pdm_pkg::OFS_STAT);
    chk("no overflow flag", 32'h0, rd);
    wake_to(pdm_pkg::SUBACT, pdm_pkg::WATCH);
  endtask

  task automatic t_sub();
    // C sub/4, G/F sub/4, serial sub/2, wdt sub/32, lcd sub, time base; then mixed; then all system clock
    logic [31:0] cfg [3] = '{32'h556e4, 32'h5b709, 32'h0};
    logic [6:0] exp [3] = '{7'h7f, 7'h75, 7'h00};
    for (int i = 0; i < 3; i++) begin
      wr(pdm_pkg::OFS_CLKSRC, cfg[i]);
      tick(1);
      chk("subactive gates", 32'(exp[i]), gv());
    end
    chk("subactive halts", 32'h0, 32'({serialReset, pwmAdcRun}));
    wr(pdm_pkg::OFS_CTRL1, 32'h08);
    sleep_to(pdm_pkg::SUBSLEEP);
    wr(pdm_pkg::OFS_CLKSRC, cfg[0]);
    tick(1);
    chk("subsleep gates", 32'h7d, gv());
    wake_to(pdm_pkg::SUBACT, pdm_pkg::SUBSLEEP);
    wr(pdm_pkg::OFS_CTRL1, 32'h80);
    wr(pdm_pkg::OFS_CTRL2, 32'h08);
    sleep_to(pdm_pkg::ACT_HS);
  endtask

  initial begin
    resetn = 1'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'h0;
    regRd = 1'h0;
    sleepReq = 1'h0;
    extIntPin = 5'h00;
    wakeupPin = 8'h00;
    aecPin = 1'h0;
    acceptDelay = 4'h4;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'h1;
    tick(1);
    t_reset();
    t_irq();
    t_speed();
    t_standby();
    t_watch();
    t_sub();
    wrapUp();
  end

  // whole run is a few thousand cycles
  initial begin
    tick(20000);
    errorCnt++;
    wrapUp();
  end
endmodule
